// ==== rtl/pio_top.sv ====
// pio_top: four-port parallel i/o and program memory of the program unit
//
// How it works
// RULE1: program memory spans 0 to 3FF
// RULE2: external reset forces program counter to zero
// RULE3: never decode port addresses 0 or 1
// RULE4: four consecutive ports, base low bits 00
// RULE5: read returns pin level ORed with latch
// RULE6: software writes 0 to input bit positions
// RULE7: read returns latches, leaves latches unchanged
// RULE8: written latch appears on pins at once
// RULE9: pins sampled only on port input
// RULE10: external logic may time with write strobe
// RULE11: drive indicator low exactly while driving bus
// RULE12: no memory address leaves the unit
// RULE13: output loads latch, input drives bus
`timescale 1ns/1ps
`default_nettype none
module pio_top
    import pio_pkg::*;
#(
    parameter logic [7:0] PORT_BASE = PIO_BASE_DEF
) (
    input  wire logic                        clk_sys,
    input  wire logic                        rst_n,
    input  wire logic                        external_reset_in,
    input  wire logic [4:0]                  cpu_control_state_code,
    input  wire logic                        write_strobe,
    input  wire logic [PIO_DW-1:0]           data_bus_in,
    output logic      [PIO_DW-1:0]           data_bus_out,
    output logic                             data_bus_oe,
    output logic                             bus_drive_indicator_n,
    input  wire logic [PIO_NPORTS*PIO_DW-1:0] port_pin_in,
    output logic      [PIO_NPORTS*PIO_DW-1:0] port_latch_out
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // base must sit on a 4-port boundary and clear the cpu's own ports
    function automatic logic port_hit(input logic [7:0] a);
        port_hit = (a[7:2] == PORT_BASE[7:2]) && (PORT_BASE[1:0] == 2'b00) // RULE4
                 && (a > PIO_CPU_PORTS) && (PORT_BASE[7:2] != 6'h00);      // RULE3
    endfunction : port_hit

    function automatic logic [PIO_DW-1:0] port_byte(input logic [PIO_NPORTS*PIO_DW-1:0] v,
                                                    input logic [1:0] idx);
        port_byte = v[idx*PIO_DW +: PIO_DW];
    endfunction : port_byte

    // pc wraps at the top of program memory instead of running past it
    function automatic logic [15:0] pc_next(input logic [15:0] pc);
        if (pc == PIO_MEM_LAST) begin
            pc_next = PIO_MEM_FIRST; // RULE1
        end else begin
            pc_next = pc + 16'h0001;
        end
    endfunction : pc_next

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    pio_mem_if mif ();

    pio_state_e                    state_ff, nxt_state;
    logic [15:0]                   pc_ff, nxt_pc;
    logic [7:0]                    port_addr_ff, nxt_port_addr;
    logic [PIO_NPORTS*PIO_DW-1:0]  latch_ff, nxt_latch;
    logic [PIO_DW-1:0]             dout_ff, nxt_dout;
    logic                          oe_ff, nxt_oe;
    logic                          drv_n_ff, nxt_drv_n;
    logic                          hit;
    logic [1:0]                    sel;
    logic                          take;
    logic                          do_fetch;
    logic                          do_store;
    logic                          do_addr;
    logic                          do_out;
    logic                          do_in;

    assign hit = port_hit(port_addr_ff);
    assign sel = port_addr_ff[1:0];

    // ------------------------------------------------------------
    // strobe decode
    // ------------------------------------------------------------
    // a strobe counts only while idle; the cycles of a bus drive ignore it
    assign take     = write_strobe && (state_ff == PIO_ST_IDLE);
    assign do_fetch = take && (cpu_control_state_code == PIO_CODE_FETCH);
    assign do_store = take && (cpu_control_state_code == PIO_CODE_MEM_STORE);
    assign do_addr  = take && (cpu_control_state_code == PIO_CODE_PORT_ADDR);
    assign do_out   = take && (cpu_control_state_code == PIO_CODE_PORT_OUT) && hit; // RULE13
    assign do_in    = take && (cpu_control_state_code == PIO_CODE_SHORT_PORT_INPUT_OP) && hit; // RULE9

    // ------------------------------------------------------------
    // program memory
    // ------------------------------------------------------------
    // address stays inside the unit; only the low bits index storage
    assign mif.addr  = pc_ff[PIO_AW-1:0]; // RULE12 RULE1
    assign mif.wdata = data_bus_in;
    assign mif.we    = do_store;

    pio_prog_mem u_mem (
        .clk_sys (clk_sys),
        .mif     (mif)
    );

    // ------------------------------------------------------------
    // port address and output latches
    // ------------------------------------------------------------
    // both survive the external reset; only rst_n clears them
    always_comb begin
        nxt_port_addr = port_addr_ff;
        nxt_latch     = latch_ff;
        if (do_addr) begin
            nxt_port_addr = data_bus_in;
        end
        if (do_out) begin
            nxt_latch[sel*PIO_DW +: PIO_DW] = data_bus_in; // RULE13 RULE8
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            port_addr_ff <= 8'h00;
            latch_ff     <= {PIO_NPORTS{PIO_LATCH_RST}};
        end else begin
            port_addr_ff <= nxt_port_addr;
            latch_ff     <= nxt_latch;
        end
    end

    // ------------------------------------------------------------
    // program counter
    // ------------------------------------------------------------
    // a store and a fetch both step on
    always_comb begin
        nxt_pc = pc_ff;
        if (do_store || (state_ff == PIO_ST_MEMRD)) begin
            nxt_pc = pc_next(pc_ff); // RULE1
        end
        // the external reset wins over a step in the same cycle
        if (external_reset_in) begin
            nxt_pc = PIO_PC_RESET; // RULE2
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pc_ff <= PIO_PC_RESET; // RULE2
        end else begin
            pc_ff <= nxt_pc;
        end
    end

    // ------------------------------------------------------------
    // bus sequencer
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_dout  = dout_ff;
        nxt_oe    = 1'b0;
        nxt_drv_n = 1'b1;
        unique case (state_ff)
            PIO_ST_IDLE: begin
                if (do_fetch) begin
                    nxt_state = PIO_ST_MEMRD;
                end
                if (do_in) begin
                    // pins are looked at here and nowhere else
                    nxt_dout  = port_byte(port_pin_in, sel)
                              | port_byte(latch_ff, sel); // RULE9 RULE5 RULE7
                    nxt_oe    = 1'b1; // RULE13
                    nxt_drv_n = 1'b0; // RULE11
                    nxt_state = PIO_ST_DRIVE;
                end
            end
            PIO_ST_MEMRD: begin
                nxt_dout  = mif.rdata;
                nxt_oe    = 1'b1;
                nxt_drv_n = 1'b0; // RULE11
                nxt_state = PIO_ST_DRIVE;
            end
            PIO_ST_DRIVE: begin
                nxt_state = PIO_ST_IDLE;
            end
            default: begin
                nxt_state = PIO_ST_IDLE;
            end
        endcase
        // a cut transfer never leaves the bus driven
        if (external_reset_in) begin
            nxt_state = PIO_ST_IDLE;
            nxt_oe    = 1'b0;
            nxt_drv_n = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_ff <= PIO_ST_IDLE;
            dout_ff  <= 8'h00;
            oe_ff    <= 1'b0;
            drv_n_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            dout_ff  <= nxt_dout;
            oe_ff    <= nxt_oe;
            drv_n_ff <= nxt_drv_n;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // indicator and enable come from twin flops so they match every cycle
    assign data_bus_out          = dout_ff;
    assign data_bus_oe           = oe_ff;
    assign bus_drive_indicator_n = drv_n_ff; // RULE11
    assign port_latch_out        = latch_ff; // RULE8
endmodule : pio_top
`default_nettype wire

// ==== rtl/pio_pkg.sv ====
// pio_pkg: constants shared by the program unit i/o port block
package pio_pkg;
    // ------------------------------------------------------------
    // widths and memory map
    // ------------------------------------------------------------
    localparam int          PIO_DW        = 8;
    localparam int          PIO_NPORTS    = 4;
    localparam int          PIO_AW        = 10;
    localparam logic [15:0] PIO_MEM_FIRST = 16'h0000;
    localparam logic [15:0] PIO_MEM_LAST  = 16'h03FF;
    localparam logic [15:0] PIO_PC_RESET  = 16'h0000;
    localparam logic [7:0]  PIO_BASE_DEF  = 8'h04;
    localparam logic [7:0]  PIO_CPU_PORTS = 8'h01;
    localparam logic [7:0]  PIO_LATCH_RST = 8'h00;

    // ------------------------------------------------------------
    // control-state codes seen on the processor's code lines
    // ------------------------------------------------------------
    localparam logic [4:0] PIO_CODE_FETCH               = 5'h00;
    localparam logic [4:0] PIO_CODE_MEM_STORE           = 5'h05;
    localparam logic [4:0] PIO_CODE_PORT_ADDR           = 5'h1C;
    localparam logic [4:0] PIO_CODE_PORT_OUT            = 5'h1A;
    localparam logic [4:0] PIO_CODE_SHORT_PORT_INPUT_OP = 5'h1B;

    typedef enum logic [2:0] {
        PIO_ST_IDLE  = 3'b001,
        PIO_ST_MEMRD = 3'b010,
        PIO_ST_DRIVE = 3'b100
    } pio_state_e;
endpackage : pio_pkg

// ==== rtl/pio_mem_if.sv ====
// pio_mem_if: program memory access bundle
`timescale 1ns/1ps
`default_nettype none
interface pio_mem_if;
    import pio_pkg::*;
    logic [PIO_AW-1:0] addr;
    logic [PIO_DW-1:0] wdata;
    logic              we;
    logic [PIO_DW-1:0] rdata;
    modport ctrl (output addr, output wdata, output we, input rdata);
    modport mem  (input addr, input wdata, input we, output rdata);
endinterface : pio_mem_if
`default_nettype wire

// ==== rtl/pio_prog_mem.sv ====
// pio_prog_mem: program memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module pio_prog_mem
    import pio_pkg::*;
(
    input  wire logic clk_sys,
    pio_mem_if.mem    mif
);
    logic [PIO_DW-1:0] mem_ff [0:(1<<PIO_AW)-1];
    logic [PIO_DW-1:0] rdata_ff;

    // no reset on the array: contents survive a restart like mask storage
    always_ff @(posedge clk_sys) begin
        if (mif.we) begin
            mem_ff[mif.addr] <= mif.wdata;
        end
        rdata_ff <= mem_ff[mif.addr];
    end

    assign mif.rdata = rdata_ff;
endmodule : pio_prog_mem
`default_nettype wire

// ==== dv/pio_ext_logic.sv ====
// pio_ext_logic: user logic standing on the port pins
`timescale 1ns/1ps
`default_nettype none
module pio_ext_logic (
    input  wire logic        clk_sys,
    input  wire logic        write_strobe,
    input  wire logic [31:0] status_in,
    output logic      [31:0] port_pin_in
);
    // status moves only on a strobe, so no read sees it change mid-cycle
    initial port_pin_in = '0;
    always @(posedge clk_sys) if (write_strobe) port_pin_in <= status_in;
endmodule : pio_ext_logic
`default_nettype wire

// ==== dv/pio_top_monitor.sv ====
// pio_top_monitor: port level checks of the i/o port block
`timescale 1ns/1ps
`default_nettype none
module pio_top_monitor
    import pio_pkg::*;
#(parameter logic [7:0] PORT_BASE = PIO_BASE_DEF) (
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        external_reset_in,
    input wire logic [4:0]  cpu_control_state_code,
    input wire logic        write_strobe,
    input wire logic [7:0]  data_bus_in,
    input wire logic [7:0]  data_bus_out,
    input wire logic        data_bus_oe,
    input wire logic        bus_drive_indicator_n,
    input wire logic [31:0] port_pin_in,
    input wire logic [31:0] port_latch_out
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    logic [7:0] adr_ff;
    wire s_in = write_strobe && cpu_control_state_code == PIO_CODE_SHORT_PORT_INPUT_OP;
    wire s_out = write_strobe && cpu_control_state_code == PIO_CODE_PORT_OUT;
    wire s_fch = write_strobe && cpu_control_state_code == PIO_CODE_FETCH;
    wire hit = adr_ff[7:2] == PORT_BASE[7:2];
    wire [7:0] sel = port_pin_in[adr_ff[1:0]*8+:8] | port_latch_out[adr_ff[1:0]*8+:8];
    always_ff @(posedge clk_sys)
        if (write_strobe && cpu_control_state_code == PIO_CODE_PORT_ADDR) adr_ff <= data_bus_in;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    property p_ind; data_bus_oe != bus_drive_indicator_n; endproperty
    a_ind: assert property (p_ind) else $error("indicator not inverse of drive");
    property p_one; data_bus_oe |=> !data_bus_oe; endproperty
    a_one: assert property (p_one) else $error("bus drive longer than a cycle");
    property p_in; s_in && hit |=> data_bus_oe && data_bus_out == $past(sel); endproperty
    a_in: assert property (p_in) else $error("port read data wrong");
    property p_miss; s_in && !hit |=> !data_bus_oe; endproperty
    a_miss: assert property (p_miss) else $error("foreign port address answered");
    property p_out; s_out && hit |=> port_latch_out[adr_ff[1:0]*8+:8] == $past(data_bus_in); endproperty
    a_out: assert property (p_out) else $error("latch not loaded");
    property p_keep; !(s_out && hit) |=> $stable(port_latch_out); endproperty
    a_keep: assert property (p_keep) else $error("latch changed without write");
    property p_fch; s_fch && !external_reset_in ##1 !external_reset_in |-> ##1 data_bus_oe; endproperty
    a_fch: assert property (p_fch) else $error("fetch drove no data");
    property p_xrst; external_reset_in |=> !data_bus_oe; endproperty
    a_xrst: assert property (p_xrst) else $error("drive during external reset");
    c_out: cover property (s_out && hit);
    c_in: cover property (s_in && hit);
    c_miss: cover property (s_in && !hit);
    c_fch: cover property (s_fch);
endmodule : pio_top_monitor
bind pio_top pio_top_monitor #(.PORT_BASE(PORT_BASE)) i_pio_top_monitor (.clk_sys(clk_sys), .rst_n(rst_n),
    .external_reset_in(external_reset_in), .cpu_control_state_code(cpu_control_state_code),
    .write_strobe(write_strobe), .data_bus_in(data_bus_in), .data_bus_out(data_bus_out),
    .data_bus_oe(data_bus_oe), .bus_drive_indicator_n(bus_drive_indicator_n),
    .port_pin_in(port_pin_in), .port_latch_out(port_latch_out));
`default_nettype wire

// ==== dv/program_unit_io_ports_test.sv ====
// program_unit_io_ports_test: self-checking bench of the i/o port block
`timescale 1ns/1ps
`default_nettype none
module program_unit_io_ports_test;
    import pio_pkg::*;
    localparam logic [7:0] B = 8'h08;
    logic clk_sys = 0, rst_n = 0, ext_rst = 0, stb = 0, oe, ind;
    logic [4:0] code = '0;
    logic [7:0] dbi = '0, dbo, d, s;
    logic [31:0] stat = '0, pins, lat;
    logic [7:0] exp_q[$];
    int errors = 0, n_compared = 0, cyc = 0;
    always #12.5 clk_sys = ~clk_sys;
    pio_top #(.PORT_BASE(B)) i_pio_top (.clk_sys(clk_sys), .rst_n(rst_n), .external_reset_in(ext_rst),
        .cpu_control_state_code(code), .write_strobe(stb), .data_bus_in(dbi), .data_bus_out(dbo),
        .data_bus_oe(oe), .bus_drive_indicator_n(ind), .port_pin_in(pins), .port_latch_out(lat));
    pio_ext_logic i_pio_ext_logic (.clk_sys(clk_sys), .write_strobe(stb), .status_in(stat), .port_pin_in(pins));
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] v);
        n_compared++;
        if (v !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, v);
        end
    endtask : chk
    task automatic op(input logic [4:0] c, input logic [7:0] v);
        @(posedge clk_sys);
        #2 stb = 1;
        code = c;
        dbi = v;
        @(posedge clk_sys);
        #2 stb = 0;
        repeat (2) @(posedge clk_sys);
    endtask : op
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        op(PIO_CODE_PORT_ADDR, a);
        op(PIO_CODE_PORT_OUT, v);
        chk("port latch", v, lat[a[1:0]*8 +: 8]);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        op(PIO_CODE_PORT_ADDR, a);
        exp_q.push_back(e);
        op(PIO_CODE_SHORT_PORT_INPUT_OP, 8'h00);
    endtask : rd
    task automatic finish_test;
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : finish_test
    // ----------------------------------------------------------------
    // result watcher and hang limit
    // ----------------------------------------------------------------
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            finish_test();
        end else if (oe === 1'b1) begin
            chk("drive indicator", 8'h00, {7'h00, ind});
            if (exp_q.size() == 0) chk("unasked drive", 8'h00, {7'h00, oe});
            else chk("bus data", exp_q.pop_front(), dbo);
        end
    end
    initial begin
        void'($urandom(32'h6657));
        repeat (6) @(posedge clk_sys);
        #2 rst_n = 1;
        op(PIO_CODE_MEM_STORE, 8'hA5);
        @(posedge clk_sys);
        #2 ext_rst = 1;
        @(posedge clk_sys);
        #2 ext_rst = 0;
        exp_q.push_back(8'hA5);
        op(PIO_CODE_FETCH, 8'h00);
        // a fetch cut by the external reset must not drive and must rewind pc
        @(posedge clk_sys);
        #2 stb = 1;
        code = PIO_CODE_FETCH;
        @(posedge clk_sys);
        #2 stb = 0;
        ext_rst = 1;
        @(posedge clk_sys);
        #2 ext_rst = 0;
        exp_q.push_back(8'hA5);
        op(PIO_CODE_FETCH, 8'h00);
        for (int p = 0; p < 4; p++) begin
            d = $urandom;
            wr(8'(B + p), d);
            rd(8'(B + p), d);
            rd(8'(B + p), d);
        end
        for (int p = 0; p < 4; p++) begin
            s = $urandom;
            d = $urandom;
            stat[p*8+:8] = {s[7:4], 4'h0};
            wr(8'(B + p), {4'h0, d[3:0]});
            rd(8'(B + p), {s[7:4], d[3:0]});
        end
        // foreign reads must leave the bus alone: no note is queued for them
        for (int i = 0; i < 4; i++) begin
            op(PIO_CODE_PORT_ADDR, 8'(i == 2 ? B - 1 : i == 3 ? B + 4 : i));
            op(PIO_CODE_SHORT_PORT_INPUT_OP, 8'h00);
        end
        repeat (4) @(posedge clk_sys);
        chk("pending results", 8'h00, 8'(exp_q.size()));
        finish_test();
    end
endmodule : program_unit_io_ports_test
`default_nettype wire
